/* File: hw/tlic_ctrl.sv */
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module tlic_ctrl
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source event pins
    input wire logic [7:0] srcEventPin,
    // core sequencer
    input wire logic coreAck,
    input wire logic returnFromIrqInstr,
    output logic vecReq,
    output logic [23:0] vecAddr,
    output logic pushReturn,
    // interrupt line
    output logic irq
);

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic [7:0] srcSync;
    logic [7:0] srcRise;

    tlic_sync uSync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .asyncIn(srcEventPin),
        .syncOut(srcSync)
    );

    tlic_edge uEdge
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .level(srcSync),
        .rise(srcRise)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] irqCtrl_q, irqCtrl_d;
    logic [7:0] rstCtrl_q;
    logic [7:0] flag_q, flag_d;
    logic [7:0] enable_q;
    logic [7:0] prio_q;
    logic [3:0] evtStat_q, evtStat_d;
    logic [3:0] evtMask_q;
    logic inHigh_q, inHigh_d;
    logic inLow_q, inLow_d;
    logic [1:0] wait_q, wait_d;
    logic vecReq_q, vecReq_d;
    logic [23:0] vecAddr_q, vecAddr_d;
    logic pushReturn_q, pushReturn_d;
    logic pendHigh_q, pendHigh_d;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_VECTOR} tlic_state_t;
    tlic_state_t state_q, state_d;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic hitOfs(input logic [7:0] a, input logic [7:0] ofs);
        hitOfs = (a == ofs);
    endfunction

    wire busSetup = psel && !penable;
    // writes land on the access edge, where the master sees ready
    wire wrEn = psel && penable && pwrite && pready_q;
    wire rdEn = busSetup && !pwrite;
    wire wrIrqCtrl = wrEn && hitOfs(paddr, tlic_pkg::OFS_IRQ_CTRL);
    wire wrRstCtrl = wrEn && hitOfs(paddr, tlic_pkg::OFS_RST_CTRL);
    wire wrFlag = wrEn && hitOfs(paddr, tlic_pkg::OFS_FLAG);
    wire wrEnable = wrEn && hitOfs(paddr, tlic_pkg::OFS_ENABLE);
    wire wrPrio = wrEn && hitOfs(paddr, tlic_pkg::OFS_PRIO);
    wire wrEvtMask = wrEn && hitOfs(paddr, tlic_pkg::OFS_EVT_MASK);
    wire rdEvtStat = rdEn && hitOfs(paddr, tlic_pkg::OFS_EVT_STAT);
    wire addrMapped = paddr[1:0] == 2'h0 && paddr <= tlic_pkg::OFS_EVT_MASK;

    // ------------------------------------------------------------
    // request qualification
    // ------------------------------------------------------------
    wire prioMode = rstCtrl_q[tlic_pkg::BIT_PRIO_MODE];
    wire gieHigh = irqCtrl_q[tlic_pkg::BIT_GIE_HIGH];
    wire gieLow = irqCtrl_q[tlic_pkg::BIT_GIE_LOW];
    wire [7:0] active = flag_q & enable_q;
    // compatibility: peripherals need bit6 too, all need bit7
    wire [7:0] compGate = {8{gieHigh}} & (~tlic_pkg::SRC_IS_PERIPH | {8{gieLow}});
    // priority mode: set prio bit uses high enable, clear uses low enable
    wire [7:0] prioGateH = {8{gieHigh}} & prio_q;
    wire [7:0] prioGateL = {8{gieLow}} & ~prio_q;
    wire reqHigh = prioMode ? |(active & prioGateH) : |(active & compGate);
    wire reqLow = prioMode && |(active & prioGateL) && !inLow_q && !inHigh_q;
    // high may interrupt low service, never itself
    wire takeHigh = reqHigh && !inHigh_q;
    wire takeAny = takeHigh || reqLow;
    wire [7:0] vecNext = (pendHigh_q) ? tlic_pkg::VEC_HIGH[7:0] : tlic_pkg::VEC_LOW[7:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        irqCtrl_d = irqCtrl_q;
        inHigh_d = inHigh_q;
        inLow_d = inLow_q;
        wait_d = wait_q;
        vecReq_d = vecReq_q;
        vecAddr_d = vecAddr_q;
        pushReturn_d = 1'b0;
        pendHigh_d = pendHigh_q;
        evtStat_d = evtStat_q;
        flag_d = flag_q;
        if (wrIrqCtrl)
            irqCtrl_d = pwdata[7:0];
        if (wrFlag)
            flag_d = pwdata[7:0];
        if (rdEvtStat)
            evtStat_d = 4'h0;
        flag_d = flag_d | srcRise;
        if (returnFromIrqInstr)
        begin
            // re-enable the level being left
            if (!prioMode || inHigh_q)
            begin
                irqCtrl_d[tlic_pkg::BIT_GIE_HIGH] = 1'b1;
                inHigh_d = 1'b0;
            end
            else
            begin
                irqCtrl_d[tlic_pkg::BIT_GIE_LOW] = 1'b1;
                inLow_d = 1'b0;
            end
            evtStat_d[tlic_pkg::EVT_RETURN] = 1'b1;
        end
        case (state_q)
            ST_IDLE:
            begin
                if (takeAny)
                begin
                    // high wins a tie, low stays pending
                    pendHigh_d = takeHigh;
                    if (takeHigh)
                    begin
                        irqCtrl_d[tlic_pkg::BIT_GIE_HIGH] = 1'b0;
                        inHigh_d = 1'b1;
                        if (inLow_q)
                            evtStat_d[tlic_pkg::EVT_PREEMPT] = 1'b1;
                    end
                    else
                    begin
                        irqCtrl_d[tlic_pkg::BIT_GIE_LOW] = 1'b0;
                        inLow_d = 1'b1;
                    end
                    wait_d = tlic_pkg::LATENCY_WAIT;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (wait_q == 2'h1)
                begin
                    vecReq_d = 1'b1;
                    vecAddr_d = {16'h0000, vecNext};
                    pushReturn_d = 1'b1;
                    evtStat_d[pendHigh_q ? tlic_pkg::EVT_VEC_HIGH : tlic_pkg::EVT_VEC_LOW] = 1'b1;
                    state_d = ST_VECTOR;
                end
                wait_d = wait_q - 2'h1;
            end
            ST_VECTOR:
            begin
                if (coreAck)
                begin
                    vecReq_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            irqCtrl_q <= tlic_pkg::RST_IRQ_CTRL;
            rstCtrl_q <= tlic_pkg::RST_RST_CTRL;
            flag_q <= 8'h00;
            enable_q <= 8'h00;
            prio_q <= tlic_pkg::RST_PRIO;
            evtStat_q <= 4'h0;
            evtMask_q <= 4'h0;
            inHigh_q <= 1'b0;
            inLow_q <= 1'b0;
            wait_q <= 2'h0;
            vecReq_q <= 1'b0;
            vecAddr_q <= 24'h000000;
            pushReturn_q <= 1'b0;
            pendHigh_q <= 1'b0;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            irqCtrl_q <= irqCtrl_d;
            flag_q <= flag_d;
            evtStat_q <= evtStat_d;
            inHigh_q <= inHigh_d;
            inLow_q <= inLow_d;
            wait_q <= wait_d;
            vecReq_q <= vecReq_d;
            vecAddr_q <= vecAddr_d;
            pushReturn_q <= pushReturn_d;
            pendHigh_q <= pendHigh_d;
            if (wrRstCtrl)
                rstCtrl_q <= pwdata[7:0];
            if (wrEnable)
                enable_q <= pwdata[7:0];
            if (wrPrio)
                prio_q <= pwdata[7:0];
            if (wrEvtMask)
                evtMask_q <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // read path and outputs
    // ------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb
    begin
        case (paddr)
            tlic_pkg::OFS_IRQ_CTRL: rdMux = {24'h000000, irqCtrl_q};
            tlic_pkg::OFS_RST_CTRL: rdMux = {24'h000000, rstCtrl_q};
            tlic_pkg::OFS_FLAG: rdMux = {24'h000000, flag_q};
            tlic_pkg::OFS_ENABLE: rdMux = {24'h000000, enable_q};
            tlic_pkg::OFS_PRIO: rdMux = {24'h000000, prio_q};
            tlic_pkg::OFS_STATUS: rdMux = {28'h0000000, pendHigh_q, inLow_q, inHigh_q, prioMode};
            tlic_pkg::OFS_EVT_STAT: rdMux = {28'h0000000, evtStat_q};
            tlic_pkg::OFS_EVT_MASK: rdMux = {28'h0000000, evtMask_q};
            default: rdMux = 32'h00000000;
        endcase
    end

    // no wait state: data captured in setup, ready in the first access cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (clkEn)
        begin
            pready_q <= busSetup;
            pslverr_q <= busSetup && !addrMapped;
            if (rdEn)
                prdata_q <= rdMux;
            irq_q <= |(evtStat_d & evtMask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign vecReq = vecReq_q;
    assign vecAddr = vecAddr_q;
    assign pushReturn = pushReturn_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !clkEn);

    sequence s_take;
        state_q == ST_IDLE && takeAny;
    endsequence

    sequence s_take_high;
        state_q == ST_IDLE && takeHigh && !wrIrqCtrl;
    endsequence

    sequence s_take_both;
        state_q == ST_IDLE && takeAny && reqHigh && reqLow;
    endsequence

    a_vector_latency: assert property (s_take |-> ##3 vecReq_q)
        else $error("vector not raised three cycles after take");
    a_high_vector: assert property ($rose(vecReq_q) && pendHigh_q |-> vecAddr_q == tlic_pkg::VEC_HIGH)
        else $error("high vector address wrong");
    a_low_vector: assert property ($rose(vecReq_q) && !pendHigh_q |-> vecAddr_q == tlic_pkg::VEC_LOW)
        else $error("low vector address wrong");
    a_compat_one_vec: assert property ($rose(vecReq_q) && !prioMode |-> vecAddr_q == tlic_pkg::VEC_HIGH)
        else $error("compatibility mode used low vector");
    a_gie_cleared: assert property (s_take_high |=> !gieHigh)
        else $error("global enable not cleared on response");
    a_gie_restored: assert property (returnFromIrqInstr && !prioMode && !wrIrqCtrl |=> gieHigh)
        else $error("return did not set global enable");
    a_flag_sticky: assert property (srcRise[0] |=> flag_q[0])
        else $error("flag not set by event");
    a_high_first: assert property (s_take_both |=> pendHigh_q && !inLow_q)
        else $error("low taken before high");
    a_push_pair: assert property ($rose(vecReq_q) |-> pushReturn_q)
        else $error("push missing with vector");
    a_no_enable: assert property (state_q == ST_IDLE && active == 8'h00 |=> state_q == ST_IDLE)
        else $error("vector without enabled source");
endmodule // tlic_ctrl

/* File: hw/tlic_edge.sv */
`timescale 1ns/100ps
module tlic_edge
(
    // clock
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // levels in, pulses out
    input wire logic [7:0] level,
    output logic [7:0] rise
);
    logic [7:0] prev_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prev_q <= 8'h00;
        else if (clkEn)
            prev_q <= level;
    end

    assign rise = level & ~prev_q;
endmodule // tlic_edge

/* File: hw/tlic_pkg.sv */
package tlic_pkg;

    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    localparam int NUM_SRC = 8;
    localparam int NUM_PERIPH_FIRST = 4;
    localparam logic [7:0] SRC_IS_PERIPH = 8'hf0;

    // ------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------
    localparam logic [23:0] VEC_HIGH = 24'h000008;
    localparam logic [23:0] VEC_LOW = 24'h000018;

    // ------------------------------------------------------------
    // apb register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h00;
    localparam logic [7:0] OFS_RST_CTRL = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_PRIO = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_EVT_STAT = 8'h18;
    localparam logic [7:0] OFS_EVT_MASK = 8'h1c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_GIE_HIGH = 7;
    localparam int BIT_GIE_LOW = 6;
    localparam int BIT_PRIO_MODE = 7;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    localparam logic [7:0] RST_RST_CTRL = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'hff;
    localparam logic [1:0] LATENCY_WAIT = 2'h2;

    typedef enum logic [1:0] {EVT_VEC_HIGH, EVT_VEC_LOW, EVT_RETURN, EVT_PREEMPT} tlic_evt_t;

endpackage

/* File: hw/tlic_sync.sv */
`timescale 1ns/100ps
module tlic_sync
(
    // clock
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // data
    input wire logic [7:0] asyncIn,
    output logic [7:0] syncOut
);
    logic [7:0] stage1_q;
    logic [7:0] stage2_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage1_q <= 8'h00;
            stage2_q <= 8'h00;
        end
        else if (clkEn)
        begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;
endmodule // tlic_sync

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
    typedef struct {logic [7:0] mode, ctrl, en, prio, src; logic [23:0] vec; logic [7:0] after;} tlic_row_t;
    logic clk = 0, sysRst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00, srcEventPin = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, coreAck, retIrq, vecReq, pushReturn, irq;
    logic [23:0] vecAddr, v;
    int fails = 0, compares = 0, n, lat0 = -1;
    tlic_row_t rows [7] = '{
        '{8'h00, 8'h80, 8'h01, 8'hff, 8'h01, 24'h000008, 8'h00},
        '{8'h00, 8'hc0, 8'h10, 8'h00, 8'h10, 24'h000008, 8'h40},
        '{8'h80, 8'hc0, 8'h02, 8'h02, 8'h02, 24'h000008, 8'h40},
        '{8'h80, 8'hc0, 8'h20, 8'h00, 8'h20, 24'h000018, 8'h80},
        '{8'h00, 8'h80, 8'h10, 8'hff, 8'h10, 24'h000000, 8'h80},
        '{8'h80, 8'h80, 8'h20, 8'h00, 8'h20, 24'h000000, 8'h80},
        '{8'h00, 8'h80, 8'h01, 8'hff, 8'h09, 24'h000008, 8'h00}};

    always #10 clk = ~clk;

    tlic_ctrl i_tlic_ctrl (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .srcEventPin(srcEventPin), .coreAck(coreAck), .returnFromIrqInstr(retIrq), .vecReq(vecReq),
        .vecAddr(vecAddr), .pushReturn(pushReturn), .irq(irq));
    tlic_core_model i_tlic_core_model (.clk(clk), .vecReq(vecReq), .vecAddr(vecAddr), .pushReturn(pushReturn),
        .coreAck(coreAck), .returnFromIrqInstr(retIrq));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++k < 16);
        if (pready !== 1'b1)
            fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask
    // raise event pins, wait for a vector entry or give up after 40 cycles
    task automatic fire(input logic [7:0] bits);
        @(posedge clk);
        srcEventPin <= bits;
        n = 0;
        do
            @(posedge clk);
        while (pushReturn !== 1'b1 && ++n < 40);
        v = (pushReturn === 1'b1) ? vecAddr : 24'h000000;
        @(posedge clk);
        srcEventPin <= 8'h00;
    endtask
    task automatic results();
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        #200000;
        fails++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        sysRst <= 1'b0;
        foreach (rows[i])
        begin
            wr(tlic_pkg::OFS_RST_CTRL, rows[i].mode);
            wr(tlic_pkg::OFS_PRIO, rows[i].prio);
            wr(tlic_pkg::OFS_ENABLE, rows[i].en);
            wr(tlic_pkg::OFS_FLAG, 8'h00);
            wr(tlic_pkg::OFS_IRQ_CTRL, rows[i].ctrl);
            fire(rows[i].src);
            chk("vector", v, rows[i].vec);
            rdc("control", tlic_pkg::OFS_IRQ_CTRL, rows[i].after);
            rdc("flags", tlic_pkg::OFS_FLAG, rows[i].src);
            wr(tlic_pkg::OFS_FLAG, 8'h00);
            if (v !== 24'h000000)
            begin
                if (lat0 < 0)
                    lat0 = n;
                if (rows[i].src[7:4] == 4'h0)
                    chk("latency", n, lat0);
                i_tlic_core_model.ret();
                rdc("control", tlic_pkg::OFS_IRQ_CTRL, rows[i].ctrl);
            end
        end
        rdc("events", tlic_pkg::OFS_EVT_STAT, 32'h7);
        rdc("events cleared", tlic_pkg::OFS_EVT_STAT, 32'h0);
        // low service preempted by high, event bit 1 unmasked only
        i_tlic_core_model.ackDelay = 0;
        wr(tlic_pkg::OFS_EVT_MASK, 8'h02);
        wr(tlic_pkg::OFS_RST_CTRL, 8'h80);
        wr(tlic_pkg::OFS_PRIO, 8'h02);
        wr(tlic_pkg::OFS_ENABLE, 8'h22);
        wr(tlic_pkg::OFS_IRQ_CTRL, 8'hc0);
        fire(8'h20);
        chk("low vector", v, tlic_pkg::VEC_LOW);
        repeat (3) @(negedge clk);
        chk("irq raised", irq, 1);
        rdc("events low", tlic_pkg::OFS_EVT_STAT, 32'h2);
        fire(8'h02);
        chk("preempt vector", v, tlic_pkg::VEC_HIGH);
        chk("stack depth", i_tlic_core_model.stack.size(), 2);
        repeat (3) @(negedge clk);
        chk("irq masked", irq, 0);
        rdc("events preempt", tlic_pkg::OFS_EVT_STAT, 32'h9);
        wr(tlic_pkg::OFS_FLAG, 8'h00);
        i_tlic_core_model.ret();
        i_tlic_core_model.ret();
        rdc("control back", tlic_pkg::OFS_IRQ_CTRL, 32'hc0);
        // both levels raised in one cycle
        fire(8'h22);
        chk("first of two", v, tlic_pkg::VEC_HIGH);
        wr(tlic_pkg::OFS_FLAG, 8'h20);
        i_tlic_core_model.ret();
        fire(8'h00);
        chk("second of two", v, tlic_pkg::VEC_LOW);
        wr(tlic_pkg::OFS_FLAG, 8'h00);
        i_tlic_core_model.ret();
        // reset values and an unmapped place
        @(posedge clk);
        sysRst <= 1'b1;
        @(posedge clk);
        sysRst <= 1'b0;
        rdc("ctrl reset", tlic_pkg::OFS_IRQ_CTRL, 32'h0);
        rdc("mode reset", tlic_pkg::OFS_RST_CTRL, 32'h0);
        rdc("prio reset", tlic_pkg::OFS_PRIO, 32'hff);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", err, 1);
        chk("unmapped data", rd, 0);
        results();
    end
endmodule // tb

/* File: tb/tlic_core_model.sv */
`timescale 1ns/100ps
module tlic_core_model
(
    // clock
    input wire logic clk,
    // vector handshake
    input wire logic vecReq,
    input wire logic [23:0] vecAddr,
    input wire logic pushReturn,
    output logic coreAck,
    output logic returnFromIrqInstr
);
    int ackDelay = 2;
    int waitCnt = 0;
    logic [23:0] pc = 24'h000100;
    logic [23:0] stack [$];

    // ------------------------------------------------------------
    // entry: push return address, jump, accept late or early
    // ------------------------------------------------------------
    initial
    begin
        coreAck = 1'b0;
        returnFromIrqInstr = 1'b0;
    end
    always @(posedge clk)
    begin
        if (pushReturn)
        begin
            stack.push_back(pc);
            pc = vecAddr;
        end
        if (!vecReq)
        begin
            coreAck <= 1'b0;
            waitCnt = 0;
        end
        else if (waitCnt++ >= ackDelay)
            coreAck <= 1'b1;
    end

    // ------------------------------------------------------------
    // return instruction
    // ------------------------------------------------------------
    task automatic ret();
        @(posedge clk);
        returnFromIrqInstr <= 1'b1;
        @(posedge clk);
        returnFromIrqInstr <= 1'b0;
        pc = stack.pop_back();
    endtask
endmodule // tlic_core_model
